// [rtl/rac_pkg.sv]
// package: constants and carriers for the register access conventions block
package rac_pkg;
	// ==========================================
	// register map, word indices on the local port
	localparam int RAC_AW = 3;
	localparam logic [2:0] RAC_IDX_CTRL = 3'h0;
	localparam logic [2:0] RAC_IDX_STATUS = 3'h1;
	localparam logic [2:0] RAC_IDX_CMD = 3'h2;
	localparam logic [2:0] RAC_IDX_DBG = 3'h3;
	localparam logic [2:0] RAC_IDX_SET = 3'h4;
	localparam logic [2:0] RAC_IDX_CLR = 3'h5;
	// ==========================================
	// field layouts
	localparam logic [7:0] RAC_CTRL_MASK = 8'h3f;
	localparam logic [7:0] RAC_STATUS_MASK = 8'h07;
	localparam logic [7:0] RAC_DBG_MASK = 8'hff;
	localparam int RAC_MODE_LSB = 4;
	localparam logic [1:0] RAC_MODE_RSVD = 2'h3;
	localparam logic [1:0] RAC_MODE_SAFE = 2'h0;
	// ==========================================
	// reset values
	localparam logic [7:0] RAC_CTRL_RST = 8'h00;
	localparam logic [7:0] RAC_DBG_RST = 8'h00;
	localparam logic [7:0] RAC_FLAGS_RST = 8'h00;
	localparam logic [7:0] RAC_CMD_RST = 8'h00;

	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [2:0] idx;
		logic [7:0] wdata;
	} rac_req_s;
endpackage : rac_pkg

// [rtl/rac_setclr.sv]
// module: shared storage behind a set/clear alias pair
`timescale 1ns/100ps
module rac_setclr import rac_pkg::*; #(
	parameter int W = 8,
	parameter logic [W-1:0] RST = '0
) (
	// clock and resets
	input wire logic mclk,
	input wire logic reset,
	input wire logic soft_reset,
	// alias writes; set and clear data kept apart so a bit set only
	// through the set alias survives a same-cycle clear of other bits
	input wire logic set_we,
	input wire logic [W-1:0] set_wdata,
	input wire logic clr_we,
	input wire logic [W-1:0] clr_wdata,
	// shared contents
	output logic [W-1:0] value
);
	logic [W-1:0] next_value;

	// next value of the shared bits
	always_comb begin
		next_value = value;
		if (set_we) begin
			next_value = next_value | set_wdata;
		end
		if (clr_we) begin
			next_value = next_value & ~clr_wdata;
		end
		if (soft_reset) begin
			next_value = RST;
		end
	end

	// storage
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			value <= RST;
		end else begin
			value <= next_value;
		end
	end

	a_clr_wins: assert property (@(posedge mclk) disable iff (reset)
		(set_we && clr_we && !soft_reset) |=> ((value & $past(set_wdata & clr_wdata)) == '0))
		else $error("clear did not win over set");
	a_zero_holds: assert property (@(posedge mclk) disable iff (reset)
		((set_we || clr_we) && !soft_reset) |=>
		(((value ^ $past(value)) & ~$past(({W{set_we}} & set_wdata) | ({W{clr_we}} & clr_wdata))) == '0))
		else $error("bit written zero changed");
endmodule : rac_setclr

// [rtl/rac_regs.sv]
// module: register bank showing the shared access conventions
// Functional notes
// - read-only bits read live, ignore writes
// - write-only bits accepted, read undefined; this bank reads them as zero
// - reserved bits always read zero
// - read-only field never shows reserved code
// - reset values; debug survives soft reset
// - clear alias ones clear shared bit
// - set alias ones set shared bit
// - both aliases read same contents
// - simultaneous writes: clear wins
`timescale 1ns/100ps
module rac_regs import rac_pkg::*; #(
	parameter int W = 8
) (
	// clock and resets
	input wire logic mclk,
	input wire logic reset,
	input wire logic soft_reset,
	// register access port
	input wire rac_req_s req,
	input wire logic alias_clr_wr,
	input wire logic [W-1:0] alias_clr_wdata,
	output logic [W-1:0] rdata,
	// block state in and out
	input wire logic [2:0] hw_status,
	output logic [W-1:0] ctrl_out,
	output logic [W-1:0] flags_out,
	output logic cmd_strobe,
	output logic [W-1:0] cmd_out
);
	// ==========================================
	// storage
	logic [W-1:0] ctrl, next_ctrl;
	logic [W-1:0] dbg, next_dbg;
	logic [W-1:0] cmd, next_cmd;
	logic strobe, next_strobe;
	logic [2:0] stat_s1, stat_s2;
	logic [W-1:0] flags;
	logic [W-1:0] next_rdata;

	// read-only mode field maps reserved code to a safe one
	function automatic logic [1:0] rac_mode_view(input logic [1:0] m);
		return (m == RAC_MODE_RSVD) ? RAC_MODE_SAFE : m;
	endfunction : rac_mode_view

	// ==========================================
	// writable registers
	always_comb begin
		next_ctrl = ctrl;
		next_dbg = dbg;
		next_cmd = cmd;
		next_strobe = 1'b0;
		if (req.wr && req.idx == RAC_IDX_CTRL) begin
			next_ctrl = req.wdata & RAC_CTRL_MASK;
		end
		if (req.wr && req.idx == RAC_IDX_DBG) begin
			next_dbg = req.wdata & RAC_DBG_MASK;
		end
		if (req.wr && req.idx == RAC_IDX_CMD) begin
			next_cmd = req.wdata;
			next_strobe = 1'b1;
		end
		if (soft_reset) begin
			next_ctrl = RAC_CTRL_RST;
			next_cmd = RAC_CMD_RST;
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			ctrl <= RAC_CTRL_RST;
			dbg <= RAC_DBG_RST;
			cmd <= RAC_CMD_RST;
			strobe <= 1'b0;
		end else begin
			ctrl <= next_ctrl;
			dbg <= next_dbg;
			cmd <= next_cmd;
			strobe <= next_strobe;
		end
	end

	// status pins come from outside, two stages first
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			stat_s1 <= 3'h0;
			stat_s2 <= 3'h0;
		end else begin
			stat_s1 <= hw_status;
			stat_s2 <= stat_s1;
		end
	end

	// ==========================================
	// set/clear pair over one storage
	rac_setclr #(.W(W), .RST(RAC_FLAGS_RST)) u_flags (
		.mclk(mclk),
		.reset(reset),
		.soft_reset(soft_reset),
		.set_we(req.wr && req.idx == RAC_IDX_SET),
		.set_wdata(req.wdata),
		.clr_we((req.wr && req.idx == RAC_IDX_CLR) || alias_clr_wr),
		.clr_wdata(((req.wr && req.idx == RAC_IDX_CLR) ? req.wdata : '0) |
			(alias_clr_wr ? alias_clr_wdata : '0)),
		.value(flags)
	);

	// ==========================================
	// read mux; unmapped reads zero
	always_comb begin
		next_rdata = '0;
		if (req.rd) begin
			case (req.idx)
				RAC_IDX_CTRL: next_rdata = ctrl & RAC_CTRL_MASK;
				RAC_IDX_STATUS: next_rdata = {3'h0, rac_mode_view(ctrl[RAC_MODE_LSB +: 2]), stat_s2} &
					{3'h7, 2'h3, RAC_STATUS_MASK[2:0]};
				RAC_IDX_CMD: next_rdata = '0;
				RAC_IDX_DBG: next_rdata = dbg;
				RAC_IDX_SET, RAC_IDX_CLR: next_rdata = flags;
				default: next_rdata = '0;
			endcase
		end
	end

	// read data registered, one cycle after the request
	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			rdata <= '0;
		end else begin
			rdata <= next_rdata;
		end
	end

	// outputs mirror state directly, no extra stage
	assign ctrl_out = ctrl;
	assign flags_out = flags;
	assign cmd_strobe = strobe;
	assign cmd_out = cmd;

	// ==========================================
	// checks
	// reserved ctrl bits zero
	a_ctrl_rsvd: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.idx == RAC_IDX_CTRL) |=> ((rdata & ~RAC_CTRL_MASK) == '0))
		else $error("reserved ctrl bit read nonzero");
	a_mode_safe: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.idx == RAC_IDX_STATUS) |=> (rdata[RAC_MODE_LSB-1 +: 2] != RAC_MODE_RSVD))
		else $error("reserved mode code visible");
	a_status_live: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.idx == RAC_IDX_STATUS) |=> (rdata[2:0] == $past(stat_s2)))
		else $error("status read not live");
	a_alias_same: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && (req.idx == RAC_IDX_SET || req.idx == RAC_IDX_CLR)) |=> (rdata == $past(flags)))
		else $error("alias read mismatch");
	a_set_bits: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.idx == RAC_IDX_SET && !alias_clr_wr && !soft_reset) |=>
		((flags & $past(req.wdata)) == $past(req.wdata)))
		else $error("set alias failed");
	a_clr_bits: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.idx == RAC_IDX_CLR) |=> ((flags & $past(req.wdata)) == '0))
		else $error("clear alias failed");
	a_dbg_keep: assert property (@(posedge mclk) disable iff (reset)
		(soft_reset && !(req.wr && req.idx == RAC_IDX_DBG)) |=> (dbg == $past(dbg) && ctrl == RAC_CTRL_RST))
		else $error("soft reset handling wrong");
	a_cmd_pulse: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.idx == RAC_IDX_CMD) |=> (cmd_strobe && cmd_out == $past(req.wdata)))
		else $error("write-only command lost");

	a_stat_rsvd: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.idx == RAC_IDX_STATUS) |=> ((rdata >> 5) == '0))
		else $error("reserved status bit read nonzero");
	a_unmapped_zero: assert property (@(posedge mclk) disable iff (reset)
		(req.rd && req.idx > RAC_IDX_CLR) |=> (rdata == '0))
		else $error("unmapped word read nonzero");
	a_ctrl_store: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.idx == RAC_IDX_CTRL && !soft_reset) |=>
		(ctrl == ($past(req.wdata) & RAC_CTRL_MASK)))
		else $error("ctrl write stored wrongly");
	a_status_nowr: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.idx == RAC_IDX_STATUS && !soft_reset) |=>
		(ctrl == $past(ctrl) && dbg == $past(dbg)))
		else $error("status write changed state");
	a_soft_values: assert property (@(posedge mclk) disable iff (reset)
		soft_reset |=>
		(cmd_out == RAC_CMD_RST && flags_out == RAC_FLAGS_RST))
		else $error("soft reset value wrong");
	a_dbg_store: assert property (@(posedge mclk) disable iff (reset)
		(req.wr && req.idx == RAC_IDX_DBG) |=> (dbg == ($past(req.wdata) & RAC_DBG_MASK)))
		else $error("debug write lost");
	a_strobe_drop: assert property (@(posedge mclk) disable iff (reset)
		!(req.wr && req.idx == RAC_IDX_CMD) |=> !cmd_strobe)
		else $error("command strobe without write");
	a_alias_port: assert property (@(posedge mclk) disable iff (reset)
		(alias_clr_wr && !soft_reset) |=> ((flags & $past(alias_clr_wdata)) == '0))
		else $error("second clear port failed");
endmodule : rac_regs

// [verification/register_access_conventions_test.sv]
// testbench: register bank access conventions
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module register_access_conventions_test import rac_pkg::*;;
	// ==========================================
	// stimulus and observed signals
	logic mclk = 1'b0;
	logic reset = 1'b1;
	logic soft_reset = 1'b0;
	rac_req_s req = '0;
	logic alias_clr_wr = 1'b0;
	logic [7:0] alias_clr_wdata = 8'h00;
	logic [2:0] hw_status = 3'h5;
	logic [7:0] rdata, ctrl_out, flags_out, cmd_out;
	logic cmd_strobe;
	int mismatches = 0;
	int n_checks = 0;

	rac_regs dut_u (.mclk(mclk), .reset(reset), .soft_reset(soft_reset), .req(req),
		.alias_clr_wr(alias_clr_wr), .alias_clr_wdata(alias_clr_wdata), .rdata(rdata),
		.hw_status(hw_status), .ctrl_out(ctrl_out), .flags_out(flags_out),
		.cmd_strobe(cmd_strobe), .cmd_out(cmd_out));

	// 20 MHz clock
	always #25 mclk = ~mclk;

	// ==========================================
	// bus cycles, driven on the falling edge
	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		@(negedge mclk);
		req.wr = 1'b1;
		req.idx = idx;
		req.wdata = d;
		@(negedge mclk);
		req.wr = 1'b0;
	endtask : wr

	// read data stands one cycle, so compare it at once
	task automatic rd(input logic [2:0] idx, input logic [7:0] e);
		@(negedge mclk);
		req.rd = 1'b1;
		req.idx = idx;
		@(negedge mclk);
		req.rd = 1'b0;
		`CHK("rdata", e, rdata)
	endtask : rd

	// ==========================================
	// scenarios
	task automatic t_reset();
		rd(RAC_IDX_CTRL, RAC_CTRL_RST);
		rd(RAC_IDX_DBG, RAC_DBG_RST);
		rd(RAC_IDX_CLR, RAC_FLAGS_RST);
	endtask : t_reset

	// status mirrors pins and mode; writes must bounce off
	task automatic t_readonly();
		wr(RAC_IDX_CTRL, 8'h10);
		rd(RAC_IDX_STATUS, 8'h0d);
		wr(RAC_IDX_STATUS, 8'h1f);
		rd(RAC_IDX_STATUS, 8'h0d);
		wr(RAC_IDX_CTRL, 8'h20);
		rd(RAC_IDX_STATUS, 8'h15);
		// pins need two edges through the synchroniser
		hw_status = 3'h2;
		repeat (2) @(negedge mclk);
		rd(RAC_IDX_STATUS, 8'h12);
	endtask : t_readonly

	task automatic t_reserved();
		wr(RAC_IDX_CTRL, 8'h2f);
		rd(RAC_IDX_CTRL, 8'h2f);
		wr(3'h6, 8'h00);
		rd(3'h6, 8'h00);
		rd(3'h7, 8'h00);
	endtask : t_reserved

	// write-only command: only its effects are judged, never its read value
	task automatic t_cmd();
		wr(RAC_IDX_CMD, 8'h5a);
		`CHK("cmd_strobe", 1'b1, cmd_strobe)
		`CHK("cmd_out", 8'h5a, cmd_out)
		@(negedge mclk);
		`CHK("cmd_strobe", 1'b0, cmd_strobe)
	endtask : t_cmd

	task automatic t_alias();
		wr(RAC_IDX_SET, 8'h0f);
		`CHK("flags_out", 8'h0f, flags_out)
		rd(RAC_IDX_SET, 8'h0f);
		rd(RAC_IDX_CLR, 8'h0f);
		wr(RAC_IDX_CLR, 8'h03);
		rd(RAC_IDX_SET, 8'h0c);
		@(negedge mclk);
		req.wr = 1'b1;
		req.idx = RAC_IDX_SET;
		req.wdata = 8'hf0;
		alias_clr_wr = 1'b1;
		alias_clr_wdata = 8'h30;
		@(negedge mclk);
		req.wr = 1'b0;
		alias_clr_wr = 1'b0;
		`CHK("flags_out", 8'hcc, flags_out)
	endtask : t_alias

	// debug control must survive a peripheral soft reset
	task automatic t_soft();
		wr(RAC_IDX_DBG, 8'ha5);
		wr(RAC_IDX_CTRL, 8'h15);
		@(negedge mclk);
		soft_reset = 1'b1;
		@(negedge mclk);
		soft_reset = 1'b0;
		rd(RAC_IDX_DBG, 8'ha5);
		rd(RAC_IDX_CTRL, RAC_CTRL_RST);
		`CHK("flags_out", RAC_FLAGS_RST, flags_out)
		`CHK("cmd_out", RAC_CMD_RST, cmd_out)
	endtask : t_soft

	// ==========================================
	// verdict
	task automatic summarize();
		if (mismatches == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : summarize

	// main sequence
	initial begin
		repeat (8) @(posedge mclk);
		@(negedge mclk);
		reset = 1'b0;
		t_reset();
		t_readonly();
		t_reserved();
		t_cmd();
		t_alias();
		t_soft();
		summarize();
	end

	// watchdog, well beyond the 66 or so cycles the tests need
	initial begin
		repeat (2000) @(posedge mclk);
		mismatches++;
		summarize();
	end
endmodule : register_access_conventions_test
